// ==== lprl_defines.svh ====
// Register offsets, reset values and timing counts for the light and proximity result logic
`ifndef LPRL_DEFINES_SVH
`define LPRL_DEFINES_SVH
`define LPRL_OFS_LIGHT_RATE     8'h45
`define LPRL_OFS_PROX_RATE      8'h46
`define LPRL_OFS_AMB_LOW        8'h4C
`define LPRL_OFS_AMB_HIGH       8'h4D
`define LPRL_OFS_PROX_RESULT    8'h4F
`define LPRL_OFS_GAIN           8'h5A
`define LPRL_GAIN_RESET         8'h35
`define LPRL_GAIN_MIN           8'h18
`define LPRL_GAIN_MAX           8'hFE
`define LPRL_RATE_RESET         8'h05
`define LPRL_CLK_HZ             125000000
`define LPRL_FINE_MS            100
`define LPRL_COARSE_MS          16
`define LPRL_PWRUP_MS           2
`define LPRL_RATE_UNIT_MS       100
`define LPRL_MS_CYCLES          (`LPRL_CLK_HZ / 1000)
`define LPRL_FINE_CYCLES        (`LPRL_FINE_MS * `LPRL_MS_CYCLES)
`define LPRL_COARSE_CYCLES      (`LPRL_COARSE_MS * `LPRL_MS_CYCLES)
`define LPRL_PWRUP_CYCLES       (`LPRL_PWRUP_MS * `LPRL_MS_CYCLES)
`define LPRL_COARSE_SHIFT       2
`endif

// ==== lprl_host_model.sv ====
// Host controller model that reads results and writes settings over the register port
module lprl_host_model (
  input  wire logic       core_clk,
  input  wire logic       ready,
  input  wire logic       power_on,
  input  wire logic       light_busy,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Bounded wait, so a stuck ready shows up as a failed read rather than a hang
  task automatic hold_off(input logic need_idle);
    int n;
    n = 0;
    while ((ready !== 1'b1 || (need_idle && (power_on !== 1'b0 || light_busy !== 1'b0)))
           && n < 5000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    hold_off(1'b1);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    hold_off(1'b0);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask
endmodule // lprl_host_model

// ==== lprl_interval_timer.sv ====
// Down-counting interval timer, reused for integration and repeat timing
module lprl_interval_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  expired
);
  initial
  begin
    if (WIDTH < 2) $error("lprl_interval_timer: WIDTH too small");
  end
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             running;
  logic             next_running;
  logic             next_expired;
  always_comb
  begin
    next_count   = count;
    next_running = running;
    next_expired = 1'b0;
    if (load)
    begin
      next_count   = load_value;
      next_running = 1'b1;
    end
    else if (running)
    begin
      if (count <= {{(WIDTH-1){1'b0}}, 1'b1})
      begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end
      else
        next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (clk_en)
    begin
      count   <= next_count;
      running <= next_running;
      expired <= next_expired;
    end
  end
endmodule // lprl_interval_timer

// ==== lprl_pkg.sv ====
// Types shared by the light and proximity result logic
package lprl_pkg;
  typedef enum logic [2:0] {
    LPRL_ST_IDLE  = 3'b001,
    LPRL_ST_INTEG = 3'b010,
    LPRL_ST_WAIT  = 3'b100
  } lprl_state_t;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lprl_reg_req_t;
  typedef struct packed {
    logic        done;
    logic [15:0] count;
  } lprl_meas_t;
endpackage

// ==== lprl_result_logic.sv ====
// Result formatting, sensitivity and sequencing for the light and proximity sensor
`include "lprl_defines.svh"
module lprl_result_logic #(
  parameter int PWRUP_CYCLES     = `LPRL_PWRUP_CYCLES,
  parameter int FINE_CYCLES      = `LPRL_FINE_CYCLES,
  parameter int COARSE_CYCLES    = `LPRL_COARSE_CYCLES,
  parameter int RATE_UNIT_CYCLES = `LPRL_RATE_UNIT_MS * `LPRL_MS_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       power_on,
  input  wire logic       coarse_mode,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [15:0] ambient_light_raw,
  input  wire logic       proximity_done,
  input  wire logic [7:0] proximity_log_value,
  output logic            ready,
  output logic            light_busy,
  output logic            int_out,
  output logic            int_oe
);
  localparam int TW = 40;
  initial
  begin
    if (PWRUP_CYCLES < 1 || FINE_CYCLES < 64 || COARSE_CYCLES < 64 || RATE_UNIT_CYCLES < 1)
      $error("lprl_result_logic: timing parameters too small");
  end

  lprl_pkg::lprl_reg_req_t req;
  lprl_pkg::lprl_meas_t    light_meas;
  lprl_pkg::lprl_state_t   state;
  lprl_pkg::lprl_state_t   next_state;
  logic [7:0]  gain;
  logic [7:0]  next_gain;
  logic [7:0]  light_rate;
  logic [7:0]  next_light_rate;
  logic [7:0]  prox_rate;
  logic [7:0]  next_prox_rate;
  logic [15:0] amb_count;
  logic [15:0] next_amb_count;
  logic [7:0]  prox_result;
  logic [7:0]  next_prox_result;
  logic [7:0]  next_reg_rdata;
  logic [31:0] pwrup_cnt;
  logic [31:0] next_pwrup_cnt;
  logic        next_ready;
  logic        next_light_busy;
  logic        integ_load;
  logic        rate_load;
  logic        integ_done;
  logic        rate_done;
  logic        rate_elapsed;
  logic        next_rate_elapsed;
  logic [TW-1:0] integ_len;
  logic [TW-1:0] rate_len;

  assign req = '{wr: reg_wr, addr: reg_addr, wdata: reg_wdata};

  // Integration length: base time times gain over 53, so time and sensitivity track gain
  always_comb
  begin
    integ_len = TW'((coarse_mode ? 64'(COARSE_CYCLES) : 64'(FINE_CYCLES)) * 64'(gain)
                    / 64'(`LPRL_GAIN_RESET));
    rate_len  = TW'(64'(light_rate) * 64'(RATE_UNIT_CYCLES));
  end

  // Coarse mode drops two bits so one count weighs four lux
  always_comb
  begin
    light_meas.done  = integ_done;
    light_meas.count = coarse_mode ? (ambient_light_raw >> `LPRL_COARSE_SHIFT)
                                   : ambient_light_raw;
  end

  lprl_interval_timer #(.WIDTH(TW)) u_integ (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .load       (integ_load),
    .load_value (integ_len),
    .expired    (integ_done)
  );

  lprl_interval_timer #(.WIDTH(TW)) u_rate (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .load       (rate_load),
    .load_value (rate_len),
    .expired    (rate_done)
  );

  // Power-up hold-off before the first register access
  always_comb
  begin
    next_pwrup_cnt = pwrup_cnt;
    next_ready     = ready;
    if (!ready)
    begin
      if (pwrup_cnt >= 32'(PWRUP_CYCLES - 1))
        next_ready = 1'b1;
      else
        next_pwrup_cnt = pwrup_cnt + 32'h0000_0001;
    end
  end

  // Measurement sequencer
  always_comb
  begin
    next_state        = state;
    integ_load        = 1'b0;
    rate_load         = 1'b0;
    next_rate_elapsed = rate_elapsed | rate_done;
    case (state)
      lprl_pkg::LPRL_ST_IDLE:
      begin
        if (power_on && ready)
        begin
          integ_load        = 1'b1;
          rate_load         = 1'b1;
          next_rate_elapsed = 1'b0;
          next_state        = lprl_pkg::LPRL_ST_INTEG;
        end
      end
      lprl_pkg::LPRL_ST_INTEG:
      begin
        if (integ_done)
        begin
          if (!power_on)
            next_state = lprl_pkg::LPRL_ST_IDLE;
          else if (rate_elapsed || rate_done)
          begin
            integ_load        = 1'b1;
            rate_load         = 1'b1;
            next_rate_elapsed = 1'b0;
          end
          else
            next_state = lprl_pkg::LPRL_ST_WAIT;
        end
      end
      lprl_pkg::LPRL_ST_WAIT:
      begin
        if (!power_on)
          next_state = lprl_pkg::LPRL_ST_IDLE;
        else if (rate_done)
        begin
          integ_load        = 1'b1;
          rate_load         = 1'b1;
          next_rate_elapsed = 1'b0;
          next_state        = lprl_pkg::LPRL_ST_INTEG;
        end
      end
      default:
        next_state = lprl_pkg::LPRL_ST_IDLE;
    endcase
    next_light_busy = (next_state == lprl_pkg::LPRL_ST_INTEG);
  end

  // Register file and results
  always_comb
  begin
    next_gain        = gain;
    next_light_rate  = light_rate;
    next_prox_rate   = prox_rate;
    next_amb_count   = amb_count;
    next_prox_result = prox_result;
    if (light_meas.done && state == lprl_pkg::LPRL_ST_INTEG)
      next_amb_count = light_meas.count;
    if (proximity_done)
      next_prox_result = proximity_log_value;
    // Gain is taken only while powered down; a write mid-measurement would skew the count
    if (req.wr && ready && !power_on && state == lprl_pkg::LPRL_ST_IDLE)
    begin
      case (req.addr)
        `LPRL_OFS_GAIN:
        begin
          if (req.wdata < `LPRL_GAIN_MIN)
            next_gain = `LPRL_GAIN_MIN;
          else if (req.wdata > `LPRL_GAIN_MAX)
            next_gain = `LPRL_GAIN_MAX;
          else
            next_gain = req.wdata;
        end
        `LPRL_OFS_LIGHT_RATE: next_light_rate = req.wdata;
        `LPRL_OFS_PROX_RATE:  next_prox_rate  = req.wdata;
        default:              next_gain       = gain;
      endcase
    end
    case (reg_addr)
      `LPRL_OFS_AMB_LOW:     next_reg_rdata = amb_count[7:0];
      `LPRL_OFS_AMB_HIGH:    next_reg_rdata = amb_count[15:8];
      `LPRL_OFS_PROX_RESULT: next_reg_rdata = prox_result;
      `LPRL_OFS_GAIN:        next_reg_rdata = gain;
      `LPRL_OFS_LIGHT_RATE:  next_reg_rdata = light_rate;
      `LPRL_OFS_PROX_RATE:   next_reg_rdata = prox_rate;
      default:               next_reg_rdata = 8'h00;
    endcase
    if (!ready)
      next_reg_rdata = 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state        <= lprl_pkg::LPRL_ST_IDLE;
      gain         <= `LPRL_GAIN_RESET;
      light_rate   <= `LPRL_RATE_RESET;
      prox_rate    <= `LPRL_RATE_RESET;
      amb_count    <= 16'h0000;
      prox_result  <= 8'h00;
      reg_rdata    <= 8'h00;
      pwrup_cnt    <= 32'h0000_0000;
      ready        <= 1'b0;
      light_busy   <= 1'b0;
      rate_elapsed <= 1'b0;
      int_out      <= 1'b0;
      int_oe       <= 1'b0;
    end
    else if (clk_en)
    begin
      state        <= next_state;
      gain         <= next_gain;
      light_rate   <= next_light_rate;
      prox_rate    <= next_prox_rate;
      amb_count    <= next_amb_count;
      prox_result  <= next_prox_result;
      reg_rdata    <= next_reg_rdata;
      pwrup_cnt    <= next_pwrup_cnt;
      ready        <= next_ready;
      light_busy   <= next_light_busy;
      rate_elapsed <= next_rate_elapsed;
      int_out      <= 1'b0;
      int_oe       <= 1'b0;
    end
  end

  AST_GAIN_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    gain >= `LPRL_GAIN_MIN && gain <= `LPRL_GAIN_MAX)
    else $error("gain setting out of range");
  AST_GAIN_FROZEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    power_on && $past(power_on) |-> $stable(gain))
    else $error("gain changed while powered");
  AST_AMB_ONLY_DONE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(integ_done) |-> $stable(amb_count))
    else $error("ambient count changed without completion");
  AST_PROX_ONLY_DONE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(proximity_done) |-> $stable(prox_result))
    else $error("proximity result changed without completion");
  AST_PROX_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
    proximity_done && clk_en |=> prox_result == $past(proximity_log_value))
    else $error("proximity code not captured");
  AST_BACK_TO_BACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == lprl_pkg::LPRL_ST_INTEG && integ_done && power_on && rate_elapsed && clk_en
    |=> state == lprl_pkg::LPRL_ST_INTEG)
    else $error("next measurement not started at once");
  AST_NO_DRIVE_INT: assert property (@(posedge core_clk) disable iff (!rst_n)
    !int_oe)
    else $error("interrupt pin driven");
  AST_READ_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && clk_en && reg_addr == `LPRL_OFS_AMB_LOW && !integ_done
    |=> reg_rdata == amb_count[7:0])
    else $error("low byte read mismatch");
  AST_NOT_READY_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(ready) |-> reg_rdata == 8'h00)
    else $error("read answered before power-up delay");
endmodule // lprl_result_logic

// ==== lprl_result_logic_tb_top.sv ====
// Self-checking testbench for the light and proximity result logic
`include "lprl_defines.svh"
module lprl_result_logic_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        power_on = 1'b0;
  logic        coarse_mode = 1'b0;
  logic [15:0] ambient_light_raw = 16'h0000;
  logic        proximity_done = 1'b0;
  logic [7:0]  proximity_log_value = 8'h00;
  logic        reg_wr;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        ready;
  logic        light_busy;
  logic        int_out;
  logic        int_oe;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #4 core_clk = ~core_clk;
  lprl_result_logic #(.PWRUP_CYCLES(10), .FINE_CYCLES(530), .COARSE_CYCLES(85),
    .RATE_UNIT_CYCLES(200)) u_lprl_result_logic (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .power_on(power_on),
    .coarse_mode(coarse_mode), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ambient_light_raw(ambient_light_raw),
    .proximity_done(proximity_done), .proximity_log_value(proximity_log_value),
    .ready(ready), .light_busy(light_busy), .int_out(int_out), .int_oe(int_oe));
  lprl_host_model u_lprl_host_model (
    .core_clk(core_clk), .ready(ready), .power_on(power_on), .light_busy(light_busy),
    .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_lprl_host_model.read_reg(a, d);
    check($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
  endtask
  task automatic do_reset();
    int n;
    n = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    while (ready !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("ready delay", {15'h0000, n >= 9 && n <= 11}, 16'h0001);
    check("pin drive", {14'h0000, int_out, int_oe}, 16'h0000);
    rd_check(`LPRL_OFS_GAIN, `LPRL_GAIN_RESET);
    rd_check(`LPRL_OFS_LIGHT_RATE, `LPRL_RATE_RESET);
    rd_check(`LPRL_OFS_PROX_RATE, `LPRL_RATE_RESET);
    rd_check(`LPRL_OFS_AMB_LOW, 8'h00);
    rd_check(`LPRL_OFS_AMB_HIGH, 8'h00);
    rd_check(`LPRL_OFS_PROX_RESULT, 8'h00);
    rd_check(8'h50, 8'h00);
    $display("test reset done");
  endtask
  // One measurement; power drops after the start so the sequence ends after it
  task automatic meas(input logic [7:0] g, input logic c, input logic [15:0] raw,
                      input int len, input logic [15:0] res);
    int n;
    n = 0;
    u_lprl_host_model.write_reg(`LPRL_OFS_GAIN, g);
    coarse_mode = c;
    ambient_light_raw = raw;
    @(posedge core_clk);
    #1;
    power_on = 1'b1;
    @(posedge core_clk);
    #1;
    power_on = 1'b0;
    while (light_busy === 1'b1 && n < 4000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("integ len", {15'h0000, n >= len - 1 && n <= len + 3}, 16'h0001);
    rd_check(`LPRL_OFS_AMB_LOW, res[7:0]);
    rd_check(`LPRL_OFS_AMB_HIGH, res[15:8]);
    $display("test meas gain %h done", g);
  endtask
  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (light_busy !== lvl && n < lim)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  initial
  begin
    int n;
    do_reset();
    u_lprl_host_model.write_reg(`LPRL_OFS_AMB_LOW, 8'hAA);
    rd_check(`LPRL_OFS_AMB_LOW, 8'h00);
    u_lprl_host_model.write_reg(`LPRL_OFS_GAIN, 8'h10);
    rd_check(`LPRL_OFS_GAIN, `LPRL_GAIN_MIN);
    u_lprl_host_model.write_reg(`LPRL_OFS_GAIN, 8'hFF);
    rd_check(`LPRL_OFS_GAIN, `LPRL_GAIN_MAX);
    do_reset();
    meas(8'h35, 1'b0, 16'h8390, 530, 16'h8390);
    meas(8'h6A, 1'b0, 16'h1234, 1060, 16'h1234);
    meas(8'h35, 1'b1, 16'h0100, 85, 16'h0040);
    meas(8'h18, 1'b1, 16'hFFFF, 38, 16'h3FFF);
    // Short integration against a longer interval: busy drops, then restarts on the interval
    u_lprl_host_model.write_reg(`LPRL_OFS_GAIN, 8'h35);
    u_lprl_host_model.write_reg(`LPRL_OFS_LIGHT_RATE, 8'h04);
    u_lprl_host_model.write_reg(`LPRL_OFS_PROX_RATE, 8'h07);
    rd_check(`LPRL_OFS_LIGHT_RATE, 8'h04);
    rd_check(`LPRL_OFS_PROX_RATE, 8'h07);
    coarse_mode = 1'b0;
    power_on = 1'b1;
    wait_busy(1'b1, 10, n);
    wait_busy(1'b0, 700, n);
    check("wait start", {15'h0000, n >= 529 && n <= 533}, 16'h0001);
    wait_busy(1'b1, 700, n);
    check("repeat gap", {15'h0000, n >= 268 && n <= 272}, 16'h0001);
    power_on = 1'b0;
    wait_busy(1'b0, 700, n);
    $display("test repeat interval done");
    u_lprl_host_model.write_reg(`LPRL_OFS_GAIN, 8'hFE);
    ambient_light_raw = 16'h0ABC;
    power_on = 1'b1;
    wait_busy(1'b1, 10, n);
    // Integration outlasts the interval, so busy must not drop across the first completion
    wait_busy(1'b0, 2700, n);
    check("restart gap", {15'h0000, n == 2700}, 16'h0001);
    ambient_light_raw = 16'h0DEF;
    repeat (50) @(posedge core_clk);
    #1;
    rd_check(`LPRL_OFS_AMB_LOW, 8'hBC);
    power_on = 1'b0;
    wait_busy(1'b0, 3000, n);
    rd_check(`LPRL_OFS_AMB_LOW, 8'hEF);
    $display("test back to back done");
    proximity_log_value = 8'h85;
    proximity_done = 1'b1;
    @(posedge core_clk);
    #1;
    proximity_done = 1'b0;
    proximity_log_value = 8'h22;
    rd_check(`LPRL_OFS_PROX_RESULT, 8'h85);
    // A completion pulse while the clock enable is low must leave the result frozen
    clk_en = 1'b0;
    proximity_log_value = 8'h33;
    proximity_done = 1'b1;
    @(posedge core_clk);
    #1;
    proximity_done = 1'b0;
    clk_en = 1'b1;
    rd_check(`LPRL_OFS_PROX_RESULT, 8'h85);
    check("pin drive", {14'h0000, int_out, int_oe}, 16'h0000);
    $display("test proximity done");
    conclude();
  end
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    conclude();
  end
endmodule // lprl_result_logic_tb_top
